// >>> logic/acsp_pkg.sv
// Package with register map, field layout and types of the converter control.
`default_nettype none
package acsp_pkg;
   // Register indices on the plain register port.
   localparam logic [3:0] ADDR_SEQ_CTRL = 4'h0;
   localparam logic [3:0] ADDR_PIN_CFG = 4'h1;
   localparam logic [3:0] ADDR_MODULE_CTRL = 4'h2;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
   // Field positions of the sequence control register.
   localparam int SCAN_BIT = 10;
   localparam int CHPS_LO = 8;
   localparam int BUFFER_HALF_STATUS_BIT = 7;
   localparam int SMPI_LO = 2;
   localparam int SPLIT_BUFFER_MODE_BIT = 1;
   localparam int ALTERNATE_SAMPLE_SELECT_BIT = 0;
   // Writable bits and reset values of the sequence control and pin configuration registers.
   localparam logic [15:0] SEQ_WMASK = 16'hE73F;
   localparam logic [15:0] PIN_WMASK = 16'h9FFF;
   localparam logic [15:0] SEQ_RESET = 16'h0000;
   localparam logic [15:0] PIN_RESET = 16'h0000;
   // Pins that exist as analog inputs on the built variant.
   localparam logic [15:0] PIN_PRESENT = 16'h9FFF;
   // Interrupt status bits.
   localparam int IRQ_SEQ_BIT = 0;
   localparam int IRQ_HALF_BIT = 1;
   localparam logic [15:0] IRQ_WMASK = 16'h0003;
   // Number of analog inputs.
   localparam int NUM_PINS = 16;

   // Register access request, write or read, carried as one bundle.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } acsp_bus_t;

   // Decoded sequencer controls.
   typedef struct packed {
      logic scan_enable;
      logic [1:0] channel_count_select;
      logic [3:0] sequences_per_interrupt;
      logic split_buffer_mode;
      logic alternate_sample_select;
   } acsp_seq_cfg_t;
endpackage
`default_nettype wire

// >>> logic/acsp_pin_gate.sv
// Pin mode gating between analog sampling and the digital read path.
`timescale 1ns/1ns
`default_nettype none
module acsp_pin_gate (
   input wire logic [15:0] pin_cfg,
   input wire logic converter_module_disable,
   input wire logic [15:0] pin_level,
   output logic [15:0] port_read,
   output logic [15:0] analog_connect,
   output logic [15:0] mux_to_ground
);
   logic [15:0] digital;

   // A disabled converter forces every shared pin digital; absent pins
   // ignore their bit and stay digital.
   assign digital = converter_module_disable ? 16'hFFFF :
      (pin_cfg | ~acsp_pkg::PIN_PRESENT);
   // Analog pins read as zero on the port; digital pins pass the level.
   assign port_read = pin_level & digital;
   // Analog pins feed the converter; digital pins tie the input to ground.
   assign analog_connect = ~digital;
   assign mux_to_ground = digital;
endmodule
`default_nettype wire

// >>> logic/acsp_seq_count.sv
// Counter of finished sequences that pulses once every N sequences.
`timescale 1ns/1ns
`default_nettype none
module acsp_seq_count (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic seq_done,
   input wire logic [3:0] sequences_per_interrupt,
   output logic irq_pulse
);
   logic [3:0] count;

   // Interrupt on the sequence whose count reaches the field value.
   assign irq_pulse = seq_done && (count >= sequences_per_interrupt);

   // Count finished sequences and restart after each interrupt.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= 4'h0;
      end else if (irq_pulse) begin
         count <= 4'h0;
      end else if (seq_done) begin
         count <= count + 4'h1;
      end
   end
endmodule
`default_nettype wire

// >>> logic/acsp_top.sv
// Sequence control and pin configuration of the analog converter.
//
// Operation
// - scan bit steps channel zero through inputs
// - channel count selects converted sample channels
// - half status shows buffer half being filled
// - interrupt after every field-plus-one sequences
// - alternate bit swaps Sample A and B
// - bit one makes pin digital, mux grounded
// - bit zero makes pin analog, read disabled; a set module disable bit keeps all pins digital
// - port read of analog pin returns zero
// - pins reset analog, software enables digital
// - bit x governs input x, 14:13 absent
// - bits of absent inputs not stored, read as zero
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module acsp_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic sample_done,
   input wire logic seq_done,
   input wire logic [15:0] pin_level,
   output logic [15:0] port_read,
   output logic [15:0] analog_connect,
   output logic [15:0] mux_to_ground,
   output logic [3:0] ch0_input,
   output logic use_sample_b,
   output logic [3:0] channels_enabled,
   output logic buffer_half_status,
   output logic irq
);
   acsp_pkg::acsp_bus_t bus;
   acsp_pkg::acsp_seq_cfg_t cfg;
   logic [15:0] seq_ctrl;
   logic [15:0] pin_cfg;
   logic converter_module_disable;
   logic [15:0] irq_status;
   logic [15:0] irq_mask;
   logic irq_pulse;
   logic [15:0] next_rdata;
   logic [3:0] scan_idx;
   logic [3:0] next_scan_idx;

   // All checks below sample on the core clock and pause during reset.
   default clocking cb_core @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // Returns the next pin after idx, wrapping past 15, that is selected for scanning.
   function automatic logic [3:0] next_selected(input logic [3:0] idx,
                                                input logic [15:0] sel);
      logic [3:0] cand;
      logic found;
      cand = idx;
      found = 1'b0;
      next_selected = idx;
      for (int i = 1; i <= acsp_pkg::NUM_PINS; i++) begin
         cand = idx + 4'(i);
         if (!found && sel[cand]) begin
            next_selected = cand;
            found = 1'b1;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register port.

   // Bundle the bus signals.
   assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

   // Sequence control; only implemented bits take writes.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         seq_ctrl <= acsp_pkg::SEQ_RESET;
      end else if (bus.wr && bus.addr == acsp_pkg::ADDR_SEQ_CTRL) begin
         seq_ctrl <= bus.wdata & acsp_pkg::SEQ_WMASK;
      end
   end

   // Pin configuration comes up all analog.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_cfg <= acsp_pkg::PIN_RESET;
      end else if (bus.wr && bus.addr == acsp_pkg::ADDR_PIN_CFG) begin
         pin_cfg <= bus.wdata & acsp_pkg::PIN_WMASK;
      end
   end

   // Module disable bit lives in bit 0 of the module control register.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         converter_module_disable <= 1'b0;
      end else if (bus.wr && bus.addr == acsp_pkg::ADDR_MODULE_CTRL) begin
         converter_module_disable <= bus.wdata[0];
      end
   end

   // Interrupt mask register.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_mask <= 16'h0000;
      end else if (bus.wr && bus.addr == acsp_pkg::ADDR_IRQ_MASK) begin
         irq_mask <= bus.wdata & acsp_pkg::IRQ_WMASK;
      end
   end

   // Sticky status: a new event wins over a write-one clear.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status <= 16'h0000;
      end else begin
         irq_status <= (irq_status &
            ~((bus.wr && bus.addr == acsp_pkg::ADDR_IRQ_STATUS) ?
              bus.wdata : 16'h0000))
            | ({15'h0000, irq_pulse} << acsp_pkg::IRQ_SEQ_BIT)
            | ({15'h0000, irq_pulse && cfg.split_buffer_mode}
               << acsp_pkg::IRQ_HALF_BIT);
      end
   end

   // Level interrupt while any unmasked status bit is set.
   assign irq = |(irq_status & irq_mask);

   // Read mux; the half status bit is inserted live.
   always_comb begin
      next_rdata = 16'h0000;
      case (bus.addr)
         acsp_pkg::ADDR_SEQ_CTRL: next_rdata = seq_ctrl |
            ({15'h0000, buffer_half_status} << acsp_pkg::BUFFER_HALF_STATUS_BIT);
         acsp_pkg::ADDR_PIN_CFG: next_rdata = pin_cfg;
         acsp_pkg::ADDR_MODULE_CTRL:
            next_rdata = {15'h0000, converter_module_disable};
         acsp_pkg::ADDR_IRQ_STATUS: next_rdata = irq_status;
         acsp_pkg::ADDR_IRQ_MASK: next_rdata = irq_mask;
         default: next_rdata = 16'h0000;
      endcase
   end

   // Read data stands in the cycle after the strobe only.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (bus.rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer.

   // Decode the control fields in one assignment, so the bundle has one driver.
   assign cfg = '{
      scan_enable: seq_ctrl[acsp_pkg::SCAN_BIT],
      channel_count_select: seq_ctrl[acsp_pkg::CHPS_LO +: 2],
      sequences_per_interrupt: seq_ctrl[acsp_pkg::SMPI_LO +: 4],
      split_buffer_mode: seq_ctrl[acsp_pkg::SPLIT_BUFFER_MODE_BIT],
      alternate_sample_select: seq_ctrl[acsp_pkg::ALTERNATE_SAMPLE_SELECT_BIT]
   };

   // Upper bit converts four channels, 01 converts two, 00 only one.
   always_comb begin
      case (cfg.channel_count_select)
         2'b00: channels_enabled = 4'h1;
         2'b01: channels_enabled = 4'h3;
         default: channels_enabled = 4'hF;
      endcase
   end

   acsp_seq_count u_count (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .seq_done(seq_done),
      .sequences_per_interrupt(cfg.sequences_per_interrupt),
      .irq_pulse(irq_pulse)
   );

   // Buffer half flips on each interrupt in split mode, else stays first.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         buffer_half_status <= 1'b0;
      end else if (!cfg.split_buffer_mode) begin
         buffer_half_status <= 1'b0;
      end else if (irq_pulse) begin
         buffer_half_status <= ~buffer_half_status;
      end
   end

   // Alternate sample: B follows A, else A always.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         use_sample_b <= 1'b0;
      end else if (!cfg.alternate_sample_select) begin
         use_sample_b <= 1'b0;
      end else if (sample_done) begin
         use_sample_b <= ~use_sample_b;
      end
   end

   // Next scan input among analog pins.
   assign next_scan_idx = next_selected(scan_idx, analog_connect);

   // Scan steps channel zero through selected inputs on Sample A.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scan_idx <= 4'h0;
      end else if (!cfg.scan_enable) begin
         scan_idx <= 4'h0;
      end else if (sample_done && !use_sample_b) begin
         scan_idx <= next_scan_idx;
      end
   end

   // Fixed input zero when not scanning.
   assign ch0_input = cfg.scan_enable ? scan_idx : 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // Pins.

   acsp_pin_gate u_pins (
      .pin_cfg(pin_cfg),
      .converter_module_disable(converter_module_disable),
      .pin_level(pin_level),
      .port_read(port_read),
      .analog_connect(analog_connect),
      .mux_to_ground(mux_to_ground)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   // Split mode toggle on an interrupt.
   sequence s_split_irq;
      cfg.split_buffer_mode && irq_pulse;
   endsequence

   // Buffer half follows interrupts only in split mode.
   AST_HALF_TOGGLE: assert property (s_split_irq |=>
      buffer_half_status != $past(buffer_half_status))
      else $error("buffer half did not toggle");
   AST_HALF_ZERO: assert property (!cfg.split_buffer_mode |=>
      !buffer_half_status)
      else $error("buffer half set outside split mode");
   AST_HALF_HOLD: assert property (
      cfg.split_buffer_mode && !irq_pulse |=> $stable(buffer_half_status))
      else $error("buffer half moved without an interrupt");

   // Interrupt every N sequences, recorded in the sticky status.
   AST_SMPI_ONE: assert property (
      seq_done && cfg.sequences_per_interrupt == 4'h0 |-> irq_pulse)
      else $error("interrupt missed with one sequence per interrupt");
   AST_STATUS_SET: assert property (
      irq_pulse |=> irq_status[acsp_pkg::IRQ_SEQ_BIT])
      else $error("interrupt event not recorded in status");

   // Pin mode gating and reserved bits.
   AST_ANALOG_READ: assert property (
      (port_read & analog_connect) == 16'h0000)
      else $error("analog pin read as one");
   AST_PIN_ANALOG: assert property (
      !converter_module_disable |->
      analog_connect == (~pin_cfg & acsp_pkg::PIN_PRESENT))
      else $error("pin mode does not follow its bit");
   AST_DISABLE_DIG: assert property (
      converter_module_disable |-> analog_connect == 16'h0000)
      else $error("pin analog while converter disabled");
   AST_GROUND: assert property (
      (mux_to_ground & ~pin_cfg & acsp_pkg::PIN_PRESENT) == 16'h0000
      || converter_module_disable)
      else $error("mux grounded on analog pin");
   AST_PIN_RESV: assert property (pin_cfg[14:13] == 2'b00)
      else $error("unimplemented pin bits set");
   AST_RD_RESV: assert property (
      bus.rd && bus.addr == acsp_pkg::ADDR_SEQ_CTRL |=>
      reg_rdata[12:11] == 2'b00 && !reg_rdata[6])
      else $error("unimplemented control bits read as one");

   // Scan, alternate sample and channel count.
   AST_NO_SCAN: assert property (
      !cfg.scan_enable |-> ch0_input == 4'h0)
      else $error("channel zero moved without scan");
   AST_SCAN_STEP: assert property (
      cfg.scan_enable && sample_done && !use_sample_b |=>
      scan_idx == $past(next_scan_idx))
      else $error("scan did not step to the next input");
   AST_ALT_A: assert property (!cfg.alternate_sample_select |=>
      !use_sample_b)
      else $error("sample B used without alternate mode");
   AST_ALT_TOGGLE: assert property (
      cfg.alternate_sample_select && sample_done |=>
      use_sample_b != $past(use_sample_b))
      else $error("sample selects did not alternate");
   AST_CHPS: assert property (
      cfg.channel_count_select[1] |-> channels_enabled == 4'hF)
      else $error("four channels not selected");
   AST_CHPS_TWO: assert property (
      cfg.channel_count_select == 2'b01 |-> channels_enabled == 4'h3)
      else $error("two channels not selected");
endmodule
`default_nettype wire

// >>> dv/test_adc_sequence_and_pin_config.sv
// Register-level testbench of the converter sequence and pin control.
`timescale 1ns/1ns
`default_nettype none
module test_adc_sequence_and_pin_config;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sample_done = 1'b0;
   logic seq_done = 1'b0;
   logic [15:0] pin_level = 16'hFFFF;
   logic [15:0] reg_rdata, port_read, analog_connect, mux_to_ground;
   logic [3:0] ch0_input, channels_enabled;
   logic use_sample_b, buffer_half_status, irq;
   logic [15:0] rd_val;
   logic [15:0] pres = acsp_pkg::PIN_PRESENT;
   int n_fail = 0;
   int checked = 0;
   int i;
   int n;

   ////////////////////////////////////////////////////////////////////////
   // The clock toggles every half period of 5 ns.
   always #5 core_clk = ~core_clk;

   // The design under test.
   acsp_top i_acsp_top (
      .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sample_done(sample_done),
      .seq_done(seq_done), .pin_level(pin_level), .port_read(port_read),
      .analog_connect(analog_connect), .mux_to_ground(mux_to_ground),
      .ch0_input(ch0_input), .use_sample_b(use_sample_b),
      .channels_enabled(channels_enabled),
      .buffer_half_status(buffer_half_status), .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // One-cycle write strobe; the register and its combinational outputs are settled when the task returns.
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // One-cycle read strobe; data is taken in the following cycle only.
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // One-cycle event pulse, then one spare edge for registered effects.
   task automatic pulse(input bit seq);
      @(posedge core_clk);
      if (seq) begin
         seq_done <= 1'b1;
      end else begin
         sample_done <= 1'b1;
      end
      @(posedge core_clk);
      seq_done <= 1'b0;
      sample_done <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   // Compares one value with its expectation.
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("Mismatches %0d, comparisons %0d", n_fail, checked);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // A hang is cut short and counted as a mismatch.
   initial begin
      #500000;
      n_fail++;
      finish_test();
   end

   // Main sequence of register accesses and event pulses.
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_reg(acsp_pkg::ADDR_SEQ_CTRL, rd_val);
      chk16(rd_val, 16'h0000);
      rd_reg(acsp_pkg::ADDR_PIN_CFG, rd_val);
      chk16(rd_val, 16'h0000);
      chk16(port_read & pres, 16'h0000);
      chk16(analog_connect & pres, pres);
      // Unmapped index and the single-cycle read data.
      wr_reg(4'hF, 16'hFFFF);
      rd_reg(4'hF, rd_val);
      chk16(rd_val, 16'h0000);
      wr_reg(acsp_pkg::ADDR_PIN_CFG, 16'hFFFF);
      rd_reg(acsp_pkg::ADDR_PIN_CFG, rd_val);
      chk16(rd_val, 16'h9FFF);
      @(posedge core_clk);
      #1;
      chk16(reg_rdata, 16'h0000);
      chk16(port_read & pres, 16'h9FFF);
      chk16(mux_to_ground & pres, 16'h9FFF);
      @(posedge core_clk);
      pin_level <= 16'hA5A5;
      wr_reg(acsp_pkg::ADDR_PIN_CFG, 16'h00F0);
      chk16(port_read & pres, 16'h00A0);
      chk16(port_read & ~pres, 16'h2000);
      chk16(analog_connect & pres, 16'h9F0F);
      chk16(mux_to_ground & pres, 16'h00F0);
      wr_reg(acsp_pkg::ADDR_MODULE_CTRL, 16'h0001);
      chk16(port_read & pres, 16'h85A5);
      chk16(analog_connect & pres, 16'h0000);
      rd_reg(acsp_pkg::ADDR_MODULE_CTRL, rd_val);
      chk16(rd_val, 16'h0001);
      wr_reg(acsp_pkg::ADDR_MODULE_CTRL, 16'h0000);
      chk16(port_read & pres, 16'h00A0);
      wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'hFFFF);
      rd_reg(acsp_pkg::ADDR_SEQ_CTRL, rd_val);
      chk16(rd_val, 16'hE73F);
      // Every channel count code.
      for (i = 0; i < 4; i++) begin
         wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'(i) << 8);
         chk16({12'h000, channels_enabled},
               (i == 0) ? 16'h0001 : (i == 1) ? 16'h0003 : 16'h000F);
      end
      // Interrupt after exactly N sequences, N being the field plus one.
      wr_reg(acsp_pkg::ADDR_IRQ_MASK, 16'h0001);
      for (i = 0; i < 3; i++) begin
         n = (i == 0) ? 1 : (i == 1) ? 2 : 16;
         wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'(n - 1) << 2);
         repeat (n - 1) pulse(1'b1);
         chk16({15'h0000, irq}, 16'h0000);
         pulse(1'b1);
         chk16({15'h0000, irq}, 16'h0001);
         rd_reg(acsp_pkg::ADDR_IRQ_STATUS, rd_val);
         chk16(rd_val, 16'h0001);
         wr_reg(acsp_pkg::ADDR_IRQ_STATUS, 16'h0001);
         chk16({15'h0000, irq}, 16'h0000);
      end
      // A masked event stays sticky and raises the line once unmasked.
      wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'h0000);
      wr_reg(acsp_pkg::ADDR_IRQ_MASK, 16'h0000);
      pulse(1'b1);
      chk16({15'h0000, irq}, 16'h0000);
      rd_reg(acsp_pkg::ADDR_IRQ_STATUS, rd_val);
      chk16(rd_val, 16'h0001);
      wr_reg(acsp_pkg::ADDR_IRQ_MASK, 16'h0001);
      chk16({15'h0000, irq}, 16'h0001);
      wr_reg(acsp_pkg::ADDR_IRQ_STATUS, 16'h0001);
      chk16({15'h0000, irq}, 16'h0000);
      // Split buffer halves alternate per interrupt.
      wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'h0002);
      pulse(1'b1);
      chk16({15'h0000, buffer_half_status}, 16'h0001);
      rd_reg(acsp_pkg::ADDR_SEQ_CTRL, rd_val);
      chk16(rd_val, 16'h0082);
      pulse(1'b1);
      chk16({15'h0000, buffer_half_status}, 16'h0000);
      rd_reg(acsp_pkg::ADDR_IRQ_STATUS, rd_val);
      chk16(rd_val, 16'h0003);
      pulse(1'b1);
      wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'h0000);
      // The half flag is a register: it clears one edge after the write.
      @(posedge core_clk);
      #1;
      chk16({15'h0000, buffer_half_status}, 16'h0000);
      pulse(1'b1);
      chk16({15'h0000, buffer_half_status}, 16'h0000);
      wr_reg(acsp_pkg::ADDR_IRQ_STATUS, 16'h0003);
      // Sample A and B selects alternate only with the bit set.
      wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'h0001);
      pulse(1'b0);
      chk16({15'h0000, use_sample_b}, 16'h0001);
      pulse(1'b0);
      chk16({15'h0000, use_sample_b}, 16'h0000);
      // Leave Sample B selected, then clearing the bit must return to A.
      pulse(1'b0);
      wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'h0000);
      @(posedge core_clk);
      #1;
      chk16({15'h0000, use_sample_b}, 16'h0000);
      pulse(1'b0);
      chk16({15'h0000, use_sample_b}, 16'h0000);
      // Scanning steps through the analog inputs 0, 2 and 5.
      wr_reg(acsp_pkg::ADDR_PIN_CFG, 16'h9FDA);
      wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'h0400);
      chk16({12'h000, ch0_input}, 16'h0000);
      for (i = 0; i < 4; i++) begin
         pulse(1'b0);
         chk16({12'h000, ch0_input},
               (i == 1) ? 16'h0005 : (i == 2) ? 16'h0000 : 16'h0002);
      end
      wr_reg(acsp_pkg::ADDR_SEQ_CTRL, 16'h0000);
      pulse(1'b0);
      chk16({12'h000, ch0_input}, 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire
